/* rtl/cca_compare.sv */
// Compare functions of the five-module shared counter array
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
module cca_compare #(
    parameter int NUM_MOD = cca_pkg::CCA_NUM_MODULES,
    parameter int CLK_PER_MC = cca_pkg::CCA_CLK_PER_MC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [cca_pkg::CCA_ADDR_W-1:0] i_addr,
    input wire logic [cca_pkg::CCA_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_tmr_tick,
    output logic [cca_pkg::CCA_DATA_W-1:0] o_rdata,
    output logic [NUM_MOD-1:0] o_pin,
    output logic o_irq_req,
    output logic o_wdog_rst
);
    import cca_pkg::*;

    // ==========================================================
    // Machine-cycle slot divider
    // ==========================================================
    localparam int SLOT_LEN = CLK_PER_MC / CCA_CMP_PER_MC;
    localparam int SLOT_W = $clog2(SLOT_LEN + 1);
    localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_LEN - 1);

    logic [SLOT_W-1:0] slot_cnt_r;
    logic cmp_slot;
    logic tick_sync1_r, tick_sync2_r, tick_sync3_r;
    logic tick_rise;
    logic tick_pend_r;

    // Slot counter: three compare slots per machine cycle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            slot_cnt_r <= '0;
        end else if (slot_cnt_r == SLOT_LAST) begin
            slot_cnt_r <= '0;
        end else begin
            slot_cnt_r <= slot_cnt_r + SLOT_W'(1);
        end
    end
    assign cmp_slot = (slot_cnt_r == SLOT_LAST);

    // Timer clock input from a pin: three-stage synchroniser
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_sync1_r <= 1'b0;
            tick_sync2_r <= 1'b0;
            tick_sync3_r <= 1'b0;
        end else begin
            tick_sync1_r <= i_tmr_tick;
            tick_sync2_r <= tick_sync1_r;
            tick_sync3_r <= tick_sync2_r;
        end
    end
    assign tick_rise = tick_sync2_r & ~tick_sync3_r;

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] mode_r [NUM_MOD];
    logic [7:0] cmpl_r [NUM_MOD];
    logic [7:0] cmph_r [NUM_MOD];
    logic [15:0] tmr_r;
    logic [15:0] tmr_nxt;
    logic [NUM_MOD-1:0] flag_r;
    logic [NUM_MOD-1:0] pin_r;
    logic [NUM_MOD-1:0] match;
    logic [NUM_MOD-1:0] irq_vec;
    logic [NUM_MOD-1:0] pwm_load;
    logic watchdog_enable_bit_r;
    logic run_r;
    logic tmr_step;
    logic wdog_fire;
    cca_fn_t fn [NUM_MOD];

    // Timer advances one count per synchronised tick, applied at a slot
    assign tmr_step = tick_pend_r & cmp_slot & run_r;
    assign tmr_nxt = tmr_r + 16'h0001;

    // Latch a tick until the next compare slot
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_pend_r <= 1'b0;
        end else if (tick_rise) begin
            tick_pend_r <= 1'b1;
        end else if (cmp_slot) begin
            tick_pend_r <= 1'b0;
        end
    end

    // Shared timer, one for all modules; software may load either byte
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tmr_r <= 16'h0000;
        end else if (i_wr && i_addr == CCA_TMRL_ADDR) begin
            tmr_r[7:0] <= i_wdata;
        end else if (i_wr && i_addr == CCA_TMRH_ADDR) begin
            tmr_r[15:8] <= i_wdata;
        end else if (tmr_step) begin
            tmr_r <= tmr_nxt;
        end
    end

    // Global control: watchdog enable and timer run
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            watchdog_enable_bit_r <= 1'b0;
            run_r <= 1'b0;
        end else if (i_wr && i_addr == CCA_COUNTER_MODE_REG_ADDR) begin
            watchdog_enable_bit_r <= i_wdata[CCA_COUNTER_MODE_REG_WATCHDOG_ENABLE_BIT];
        end else if (i_wr && i_addr == CCA_CTRL_ADDR) begin
            run_r <= i_wdata[CCA_CTRL_RUN];
        end
    end

    // ==========================================================
    // Per-module logic
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < NUM_MOD; g++) begin : g_mod
            logic mode_hit, cmpl_hit, cmph_hit;
            logic en, mat, tog, pwm, capn, capp;
            assign mode_hit = i_wr && (i_addr == CCA_MODE_BASE + 8'(g));
            assign cmpl_hit = i_wr && (i_addr == CCA_CMPL_BASE + 8'(g));
            assign cmph_hit = i_wr && (i_addr == CCA_CMPH_BASE + 8'(g));
            assign en = mode_r[g][CCA_MODE_CMPEN];
            assign mat = mode_r[g][CCA_MODE_MAT];
            assign tog = mode_r[g][CCA_MODE_TOG];
            assign pwm = mode_r[g][CCA_MODE_PWM];
            assign capn = mode_r[g][CCA_MODE_CAPN];
            assign capp = mode_r[g][CCA_MODE_CAPP];

            // Function decode from the mode bits
            always_comb begin
                if (en && !capp && !capn && mat && !pwm) begin
                    fn[g] = tog ? CCA_FN_TOGGLE : CCA_FN_SWTMR;
                end else if (en && !capp && !capn && !mat && !tog && pwm) begin
                    fn[g] = CCA_FN_PWM;
                end else if (mode_r[g] == CCA_MODE_RST) begin
                    fn[g] = CCA_FN_IDLE;
                end else begin
                    fn[g] = CCA_FN_OTHER;
                end
            end

            // 16-bit match, sampled at each compare slot, only while enabled
            assign match[g] = cmp_slot && en && ({cmph_r[g], cmpl_r[g]} == tmr_r);
            // Low byte reload when the timer low byte wraps to zero
            assign pwm_load[g] = tmr_step && (tmr_r[7:0] == CCA_BYTE_MAX) &&
                                 (fn[g] == CCA_FN_PWM);

            // Mode register; low-byte write clears enable, high-byte write sets it
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    mode_r[g] <= CCA_MODE_RST;
                end else if (mode_hit) begin
                    mode_r[g] <= i_wdata;
                end else if (cmpl_hit) begin
                    mode_r[g][CCA_MODE_CMPEN] <= 1'b0;
                end else if (cmph_hit) begin
                    mode_r[g][CCA_MODE_CMPEN] <= 1'b1;
                end
            end

            // Compare bytes; hardware loads low from high in pulse-width mode
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    cmpl_r[g] <= CCA_BYTE_RST;
                    cmph_r[g] <= CCA_BYTE_RST;
                end else begin
                    if (cmpl_hit) begin
                        cmpl_r[g] <= i_wdata;
                    end else if (pwm_load[g]) begin
                        cmpl_r[g] <= cmph_r[g];
                    end
                    if (cmph_hit) begin
                        cmph_r[g] <= i_wdata;
                    end
                end
            end

            // Event flag: set on match in timer or toggle mode, cleared by writing 0 to its counter control bit
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    flag_r[g] <= 1'b0;
                end else if (match[g] && (fn[g] == CCA_FN_SWTMR || fn[g] == CCA_FN_TOGGLE)) begin
                    flag_r[g] <= 1'b1;
                end else if (i_wr && i_addr == CCA_COUNTER_CONTROL_REG_ADDR && !i_wdata[g]) begin
                    flag_r[g] <= 1'b0;
                end
            end
            assign irq_vec[g] = flag_r[g] && mode_r[g][CCA_MODE_IRQEN];

            // Pin: software preset, toggle on match, or pulse-width compare
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    pin_r[g] <= 1'b1;
                end else if (i_wr && i_addr == CCA_PIN_ADDR) begin
                    pin_r[g] <= i_wdata[g];
                end else if (fn[g] == CCA_FN_TOGGLE && match[g]) begin
                    pin_r[g] <= ~pin_r[g];
                end else if (fn[g] == CCA_FN_PWM && cmp_slot) begin
                    pin_r[g] <= (tmr_r[7:0] >= cmpl_r[g]);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Watchdog on module 4
    // ==========================================================
    assign wdog_fire = watchdog_enable_bit_r && match[CCA_WDOG_MODULE] &&
                       (fn[CCA_WDOG_MODULE] == CCA_FN_SWTMR ||
                        fn[CCA_WDOG_MODULE] == CCA_FN_TOGGLE);

    // One reset pulse per match event
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wdog_rst <= 1'b0;
        end else begin
            o_wdog_rst <= wdog_fire;
        end
    end

    // Interrupt request level from any enabled flag
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_req <= 1'b0;
        end else begin
            o_irq_req <= |irq_vec;
        end
    end
    assign o_pin = pin_r;

    // ==========================================================
    // Read port, data valid the cycle after the strobe
    // ==========================================================
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = CCA_READ_ZERO;
        for (int i = 0; i < NUM_MOD; i++) begin
            if (i_addr == CCA_MODE_BASE + 8'(i)) rd_mux = mode_r[i];
            if (i_addr == CCA_CMPL_BASE + 8'(i)) rd_mux = cmpl_r[i];
            if (i_addr == CCA_CMPH_BASE + 8'(i)) rd_mux = cmph_r[i];
        end
        if (i_addr == CCA_TMRL_ADDR) rd_mux = tmr_r[7:0];
        if (i_addr == CCA_TMRH_ADDR) rd_mux = tmr_r[15:8];
        if (i_addr == CCA_COUNTER_MODE_REG_ADDR) rd_mux = 8'(watchdog_enable_bit_r) << CCA_COUNTER_MODE_REG_WATCHDOG_ENABLE_BIT;
        if (i_addr == CCA_COUNTER_CONTROL_REG_ADDR) rd_mux = 8'(flag_r);
        if (i_addr == CCA_PIN_ADDR) rd_mux = 8'(pin_r);
        if (i_addr == CCA_CTRL_ADDR) rd_mux = 8'(run_r);
    end

    // Read data register, zero when no read
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= CCA_READ_ZERO;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= CCA_READ_ZERO;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    lo_clears_en_a: assert property ((i_wr && i_addr == CCA_CMPL_BASE) |=>
        !mode_r[0][CCA_MODE_CMPEN]) else $error("low write did not clear enable");
    hi_sets_en_a: assert property ((i_wr && i_addr == CCA_CMPH_BASE) |=>
        mode_r[0][CCA_MODE_CMPEN]) else $error("high write did not set enable");
    match_flag_a: assert property ((match[0] && fn[0] == CCA_FN_SWTMR) |=>
        flag_r[0]) else $error("match did not set flag");
    flag_sticky_a: assert property ((flag_r[1] && !(i_wr && i_addr == CCA_COUNTER_CONTROL_REG_ADDR)) |=>
        flag_r[1]) else $error("flag cleared by hardware");
    no_match_off_a: assert property (!mode_r[2][CCA_MODE_CMPEN] |-> !match[2])
        else $error("match while disabled");
    toggle_pin_a: assert property ((fn[3] == CCA_FN_TOGGLE && match[3] &&
        !(i_wr && i_addr == CCA_PIN_ADDR)) |=> pin_r[3] != $past(pin_r[3]))
        else $error("pin did not toggle");
    wdog_pulse_a: assert property (wdog_fire |=> o_wdog_rst ##1 !o_wdog_rst)
        else $error("watchdog pulse wrong");
    wdog_off_a: assert property (!watchdog_enable_bit_r |=> !o_wdog_rst)
        else $error("watchdog reset while disabled");
    pwm_level_a: assert property ((fn[0] == CCA_FN_PWM && cmp_slot &&
        !(i_wr && i_addr == CCA_PIN_ADDR)) |=> pin_r[0] == ($past(tmr_r[7:0]) >= $past(cmpl_r[0])))
        else $error("pulse level wrong");
    slot_rate_a: assert property (cmp_slot |=> !cmp_slot [*3] ##1 cmp_slot)
        else $error("compare slot spacing wrong");

    // ==========================================================
    // Assertions on reload, pulse level, preset, watchdog source, timer step and flag set priority
    // ==========================================================
    // Period reload copies the high byte unless software writes the low byte
    pwm_reload_a: assert property ((pwm_load[2] && !(i_wr && i_addr == CCA_CMPL_BASE + 8'h02)) |=>
        cmpl_r[2] == $past(cmph_r[2])) else $error("period reload wrong");

    // Equal low bytes drive the pulse output high
    pwm_equal_a: assert property ((fn[2] == CCA_FN_PWM && cmp_slot &&
        tmr_r[7:0] == cmpl_r[2] && !(i_wr && i_addr == CCA_PIN_ADDR)) |=> pin_r[2])
        else $error("pulse level at equal wrong");

    // Software preset lands on every pin at once
    pin_preset_a: assert property ((i_wr && i_addr == CCA_PIN_ADDR) |=>
        pin_r == $past(i_wdata[NUM_MOD-1:0])) else $error("pin preset lost");

    // A watchdog pulse only follows a match on the watchdog module
    wdog_src_a: assert property (o_wdog_rst |-> $past(match[CCA_WDOG_MODULE]))
        else $error("watchdog pulse without match");

    // Timer steps by one when no software load competes
    tmr_step_a: assert property ((tmr_step && !(i_wr && (i_addr == CCA_TMRL_ADDR ||
        i_addr == CCA_TMRH_ADDR))) |=> tmr_r == $past(tmr_nxt))
        else $error("timer step wrong");

    // Match set beats a same-cycle software clear
    flag_set_a: assert property ((match[1] && fn[1] == CCA_FN_SWTMR) |=> flag_r[1])
        else $error("flag set lost");

    // Scenario covers
    swtmr_c: cover property (match[0] && fn[0] == CCA_FN_SWTMR);
    toggle_c: cover property (match[1] && fn[1] == CCA_FN_TOGGLE);
    pwm_c: cover property (pwm_load[2]);
    wdog_c: cover property (o_wdog_rst);
endmodule

/* rtl/cca_pkg.sv */
// Package for the counter array compare block: map, field layout, reset values
package cca_pkg;
    // Number of modules sharing the timer
    localparam int CCA_NUM_MODULES = 5;
    // Module that carries the watchdog
    localparam int CCA_WDOG_MODULE = 4;
    // Compare slots per machine cycle
    localparam int CCA_CMP_PER_MC = 3;
    // Core clocks per machine cycle (12 oscillator periods)
    localparam int CCA_CLK_PER_MC = 12;

    localparam int CCA_ADDR_W = 8;
    localparam int CCA_DATA_W = 8;

    // Register map: per-module registers at base + module index
    localparam logic [7:0] CCA_MODE_BASE = 8'h00;
    localparam logic [7:0] CCA_CMPL_BASE = 8'h08;
    localparam logic [7:0] CCA_CMPH_BASE = 8'h10;
    localparam logic [7:0] CCA_TMRL_ADDR = 8'h18;
    localparam logic [7:0] CCA_TMRH_ADDR = 8'h19;
    localparam logic [7:0] CCA_COUNTER_MODE_REG_ADDR = 8'h1A;
    localparam logic [7:0] CCA_COUNTER_CONTROL_REG_ADDR = 8'h1B;
    localparam logic [7:0] CCA_PIN_ADDR = 8'h1C;
    localparam logic [7:0] CCA_CTRL_ADDR = 8'h1D;

    // Mode register field positions
    localparam int CCA_MODE_IRQEN = 0;
    localparam int CCA_MODE_PWM = 1;
    localparam int CCA_MODE_TOG = 2;
    localparam int CCA_MODE_MAT = 3;
    localparam int CCA_MODE_CAPN = 4;
    localparam int CCA_MODE_CAPP = 5;
    localparam int CCA_MODE_CMPEN = 6;
    // Counter mode register: watchdog enable position
    localparam int CCA_COUNTER_MODE_REG_WATCHDOG_ENABLE_BIT = 6;
    // Control register: timer run bit
    localparam int CCA_CTRL_RUN = 0;

    localparam logic [7:0] CCA_MODE_RST = 8'h00;
    localparam logic [7:0] CCA_BYTE_RST = 8'h00;
    localparam logic [7:0] CCA_BYTE_MAX = 8'hFF;
    localparam logic [7:0] CCA_READ_ZERO = 8'h00;

    // Decoded module function
    typedef enum logic [2:0] {
        CCA_FN_IDLE = 3'b000,
        CCA_FN_SWTMR = 3'b001,
        CCA_FN_TOGGLE = 3'b010,
        CCA_FN_PWM = 3'b011,
        CCA_FN_OTHER = 3'b100
    } cca_fn_t;
endpackage

/* sim/cca_pin_load.sv */
// Load on the module pins: integrates the high time of one pin
`timescale 1ns/10ps
module cca_pin_load (
    input wire logic i_core_clk,
    input wire logic [4:0] i_pin,
    input wire logic [2:0] i_sel,
    input wire logic i_clear,
    output int o_high,
    output int o_total
);
    // Filter model: counts high cycles of the selected pin
    always @(posedge i_core_clk) begin
        if (i_clear) begin
            o_high <= 0;
            o_total <= 0;
        end else begin
            o_high <= o_high + int'(i_pin[i_sel]);
            o_total <= o_total + 1;
        end
    end
endmodule

/* sim/tb.sv */
// Self-checking bench for the counter array compare block
`timescale 1ns/10ps
module tb;
    import cca_pkg::*;
    // ==========================================
    // Signals and instances
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_tmr_tick = 1'b0;
    logic [7:0] o_rdata;
    logic [4:0] o_pin;
    logic o_irq_req;
    logic o_wdog_rst;
    logic ld_clear = 1'b1;
    int ld_high;
    int ld_total;
    int err_total = 0;
    int num_checks = 0;
    int wdog_cnt = 0;
    logic [7:0] rv;
    logic [7:0] modes [6] = '{8'h00, 8'h08, 8'h48, 8'h49, 8'h4C, 8'h68};
    logic [2:0] expv [6] = '{3'b001, 3'b001, 3'b101, 3'b111, 3'b100, 3'b001};

    always #5 i_core_clk = ~i_core_clk;

    cca_compare #(.NUM_MOD(5), .CLK_PER_MC(CCA_CLK_PER_MC)) i_cca_compare (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_tmr_tick(i_tmr_tick),
        .o_rdata(o_rdata), .o_pin(o_pin), .o_irq_req(o_irq_req),
        .o_wdog_rst(o_wdog_rst));

    cca_pin_load i_cca_pin_load (.i_core_clk(i_core_clk), .i_pin(o_pin),
        .i_sel(3'h2), .i_clear(ld_clear), .o_high(ld_high), .o_total(ld_total));

    // Counts cycles with the internal reset request high
    always @(posedge i_core_clk) begin
        if (o_wdog_rst === 1'b1) begin
            wdog_cnt <= wdog_cnt + 1;
        end
    end

    // ==========================================
    // Bus and helper tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            i_tmr_tick <= 1'b1;
            gap(4);
            i_tmr_tick <= 1'b0;
            gap(4);
        end
    endtask

    task automatic cmp_set(input int n, input logic [15:0] v);
        wr(CCA_CMPL_BASE + 8'(n), v[7:0]);
        wr(CCA_CMPH_BASE + 8'(n), v[15:8]);
    endtask

    // Timer holds v for exactly four edges, so one compare slot sees it
    task automatic match_once(input logic [15:0] v);
        wr(CCA_TMRH_ADDR, v[15:8] ^ 8'h01);
        wr(CCA_TMRL_ADDR, v[7:0]);
        wr(CCA_TMRH_ADDR, v[15:8]);
        gap(2);
        wr(CCA_TMRH_ADDR, v[15:8] ^ 8'h01);
        gap(3);
    endtask

    task automatic clear_all();
        for (int n = 0; n < 5; n++) begin
            wr(CCA_MODE_BASE + 8'(n), 8'h00);
        end
        wr(CCA_COUNTER_MODE_REG_ADDR, 8'h00);
        wr(CCA_COUNTER_CONTROL_REG_ADDR, 8'h00);
        wr(CCA_PIN_ADDR, 8'h1F);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        for (int n = 0; n < 5; n++) begin
            rd(CCA_MODE_BASE + 8'(n));
            chk("mode reset", 16'(CCA_MODE_RST), 16'(rv));
        end
        rd(CCA_PIN_ADDR);
        chk("pin reset", 16'h001F, 16'(rv));
        wr(8'h1F, 8'hFF);
        rd(8'h1F);
        chk("unmapped", 16'h0000, 16'(rv));
        gap(1);
        #1;
        chk("rdata idle", 16'h0000, 16'(o_rdata));
        $display("test reset done");
    endtask

    task automatic t_modes();
        for (int k = 0; k < 6; k++) begin
            clear_all();
            cmp_set(1, 16'h1234);
            wr(CCA_MODE_BASE + 8'h01, modes[k]);
            match_once(16'h1234);
            rd(CCA_COUNTER_CONTROL_REG_ADDR);
            chk("flag", 16'(expv[k][2]), 16'(rv[1]));
            chk("irq", 16'(expv[k][1]), 16'(o_irq_req));
            chk("pin", 16'(expv[k][0]), 16'(o_pin[1]));
        end
        $display("test modes done");
    endtask

    task automatic t_bytes();
        clear_all();
        wr(CCA_MODE_BASE, 8'h48);
        wr(CCA_CMPL_BASE, 8'h34);
        rd(CCA_MODE_BASE);
        chk("enable cleared", 16'h0008, 16'(rv));
        match_once(16'h0034);
        rd(CCA_COUNTER_CONTROL_REG_ADDR);
        chk("no match", 16'h0000, 16'(rv));
        wr(CCA_CMPH_BASE, 8'h00);
        rd(CCA_MODE_BASE);
        chk("enable set", 16'h0048, 16'(rv));
        match_once(16'h0034);
        rd(CCA_COUNTER_CONTROL_REG_ADDR);
        chk("match", 16'h0001, 16'(rv));
        $display("test bytes done");
    endtask

    task automatic t_toggle();
        clear_all();
        cmp_set(0, 16'h0F0F);
        cmp_set(3, 16'h0F0F);
        wr(CCA_MODE_BASE, 8'h4C);
        wr(CCA_MODE_BASE + 8'h03, 8'h4C);
        wr(CCA_PIN_ADDR, 8'h16);
        match_once(16'h0F0F);
        chk("rise", 16'h001F, 16'(o_pin));
        match_once(16'h0F0F);
        chk("wrap", 16'h0016, 16'(o_pin));
        wr(CCA_PIN_ADDR, 8'h1F);
        match_once(16'h0F0F);
        chk("fall", 16'h0016, 16'(o_pin));
        $display("test toggle done");
    endtask

    task automatic t_wdog();
        int base;
        clear_all();
        cmp_set(0, 16'h2222);
        cmp_set(4, 16'h3333);
        wr(CCA_MODE_BASE, 8'h48);
        wr(CCA_MODE_BASE + 8'h04, 8'h48);
        wr(CCA_COUNTER_MODE_REG_ADDR, 8'h40);
        base = wdog_cnt;
        match_once(16'h2222);
        chk("module0", 16'(base), 16'(wdog_cnt));
        match_once(16'h3333);
        chk("one pulse", 16'(base + 1), 16'(wdog_cnt));
        rd(CCA_COUNTER_CONTROL_REG_ADDR);
        chk("flags", 16'h0011, 16'(rv));
        wr(CCA_COUNTER_MODE_REG_ADDR, 8'h00);
        match_once(16'h3333);
        chk("disarmed", 16'(base + 1), 16'(wdog_cnt));
        wr(CCA_COUNTER_MODE_REG_ADDR, 8'h40);
        match_once(16'h3333);
        chk("rearmed", 16'(base + 2), 16'(wdog_cnt));
        cmp_set(4, 16'h4444);
        match_once(16'h3333);
        chk("held off", 16'(base + 2), 16'(wdog_cnt));
        cmp_set(4, 16'h3333);
        wr(CCA_MODE_BASE + 8'h04, 8'h42);
        match_once(16'h3333);
        chk("pwm mode", 16'(base + 2), 16'(wdog_cnt));
        $display("test watchdog done");
    endtask

    task automatic t_run();
        clear_all();
        wr(CCA_TMRL_ADDR, 8'h00);
        wr(CCA_TMRH_ADDR, 8'h00);
        cmp_set(0, 16'h0005);
        cmp_set(1, 16'h0007);
        wr(CCA_MODE_BASE, 8'h49);
        wr(CCA_MODE_BASE + 8'h01, 8'h48);
        wr(CCA_CTRL_ADDR, 8'h01);
        ticks(9);
        gap(4);
        rd(CCA_COUNTER_CONTROL_REG_ADDR);
        chk("run flags", 16'h0003, 16'(rv));
        chk("run irq", 16'h0001, 16'(o_irq_req));
        ticks(4);
        gap(4);
        rd(CCA_TMRL_ADDR);
        chk("count", 16'h000D, 16'(rv));
        rd(CCA_COUNTER_CONTROL_REG_ADDR);
        chk("flags kept", 16'h0003, 16'(rv));
        wr(CCA_COUNTER_CONTROL_REG_ADDR, 8'h02);
        rd(CCA_COUNTER_CONTROL_REG_ADDR);
        chk("flag cleared", 16'h0002, 16'(rv));
        chk("irq off", 16'h0000, 16'(o_irq_req));
        wr(CCA_CTRL_ADDR, 8'h00);
        $display("test run done");
    endtask

    task automatic t_pwm();
        logic [7:0] tl [3] = '{8'h3F, 8'h40, 8'h41};
        logic [7:0] duty [2] = '{8'hC0, 8'h00};
        int exp;
        clear_all();
        cmp_set(2, 16'h4040);
        wr(CCA_MODE_BASE + 8'h02, 8'h42);
        for (int k = 0; k < 3; k++) begin
            wr(CCA_TMRL_ADDR, tl[k]);
            gap(6);
            chk("pwm pin", 16'(k != 0), 16'(o_pin[2]));
        end
        foreach (duty[k]) begin
            wr(CCA_CTRL_ADDR, 8'h00);
            wr(CCA_TMRL_ADDR, 8'hFF);
            wr(CCA_CMPH_BASE + 8'h02, duty[k]);
            rd(CCA_CMPL_BASE + 8'h02);
            chk("no early copy", 16'(k == 0 ? 8'h40 : 8'hC0), 16'(rv));
            wr(CCA_CTRL_ADDR, 8'h01);
            ticks(1);
            ld_clear <= 1'b0;
            ticks(256);
            ld_clear <= 1'b1;
            exp = (256 - int'(duty[k])) * 8;
            num_checks++;
            if (ld_high < exp - 24 || ld_high > exp + 24) begin
                err_total++;
                $display("CHECK FAILED duty expected %0d seen %0d", exp, ld_high);
            end
        end
        wr(CCA_CTRL_ADDR, 8'h00);
        $display("test pwm done");
    endtask

    // ==========================================
    // Sequence, verdict and watchdog
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_reset();
        t_modes();
        t_bytes();
        t_toggle();
        t_wdog();
        t_run();
        t_pwm();
        wrap_up();
    end

    initial begin
        #500000;
        err_total++;
        wrap_up();
    end
endmodule
